// ===== verilog/cfg_word_pkg.sv
package cfg_word_pkg;

  // ----------------------------------------------------------------
  // Word geometry and register map
  // ----------------------------------------------------------------
  localparam int CFG_W      = 24;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int NUM_FIELDS = 11;

  localparam logic [AXI_ADDR_W-1:0] CFG_OFFSET    = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REV_OFFSET    = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] STATUS_OFFSET = 8'h08;

  // ----------------------------------------------------------------
  // Configuration word fields
  // ----------------------------------------------------------------
  localparam int SCAN_BIT   = 14;
  localparam int CP_BIT     = 13;
  localparam int WP_BIT     = 12;
  localparam int DBG_BIT    = 11;
  localparam int ICS_LSB    = 8;
  localparam int WDTEN_BIT  = 7;
  localparam int WINDOW_WATCHDOG_OFF_BIT = 6;
  localparam int PSA_BIT    = 4;

  localparam logic [CFG_W-1:0] CFG_BLANK       = 24'hFF_FFFF;
  localparam logic [CFG_W-1:0] CFG_UNIMPL_MASK = 24'hFF_0000;

  // One entry per separately programmable field, index 2 is code protection.
  localparam logic [CFG_W-1:0] FIELD_MASK [NUM_FIELDS] = '{
    24'h00_8000, 24'h00_4000, 24'h00_2000, 24'h00_1000, 24'h00_0800, 24'h00_0400,
    24'h00_0300, 24'h00_0080, 24'h00_0040, 24'h00_0010, 24'h00_000F};
  localparam int CP_FIELD = 2;

  localparam logic [1:0] ICS_PAIR1 = 2'h3;
  localparam logic [1:0] ICS_PAIR2 = 2'h2;
  localparam logic [1:0] ICS_PAIR3 = 2'h1;

  localparam logic [7:0] PRESCALE_HI = 8'h80;
  localparam logic [7:0] PRESCALE_LO = 8'h20;

  // ----------------------------------------------------------------
  // Revision and status layout, bus answers
  // ----------------------------------------------------------------
  localparam int MAJOR_LSB         = 6;
  localparam int MINOR_LSB         = 0;
  localparam int STATUS_FAULT_BIT  = 16;
  localparam int STATUS_LOADED_BIT = 17;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_LOAD   = 3'h1,
    ST_DECODE = 3'h2,
    ST_RUN    = 3'h4
  } load_state_t;

  typedef struct packed {
    logic       scanEn;
    logic       codeProtect;
    logic       writeProtect;
    logic       debugBoot;
    logic [2:0] pairSel;
    logic       wdtOn;
    logic       windowed;
    logic [7:0] prescale;
    logic       fault;
  } decoded_t;

  // Decode of an unprogrammed word.
  localparam decoded_t DECODED_RST = '{scanEn: 1'h1, codeProtect: 1'h0, writeProtect: 1'h0,
                                       debugBoot: 1'h0, pairSel: 3'h1, wdtOn: 1'h1,
                                       windowed: 1'h0, prescale: 8'h80, fault: 1'h0};

endpackage

// ===== verilog/cfg_decode_if.sv
`timescale 1ns/1ps
interface cfg_decode_if;
  import cfg_word_pkg::*;

  logic [CFG_W-1:0] word;
  decoded_t         dec;

  modport source  (output word, input dec);
  modport decoder (input word, output dec);
endinterface

// ===== verilog/cfg_field_decode.sv
`timescale 1ns/1ps
module cfg_field_decode (
  // Stored word in, decoded settings out
  cfg_decode_if.decoder dif
);
  import cfg_word_pkg::*;

  always_comb begin
    dif.dec.scanEn       = dif.word[SCAN_BIT];
    dif.dec.codeProtect  = !dif.word[CP_BIT];
    dif.dec.writeProtect = !dif.word[WP_BIT];
    dif.dec.debugBoot    = !dif.word[DBG_BIT];
    case (dif.word[ICS_LSB+:2])
      ICS_PAIR1: dif.dec.pairSel = 3'h1;
      ICS_PAIR2: dif.dec.pairSel = 3'h2;
      ICS_PAIR3: dif.dec.pairSel = 3'h4;
      default:   dif.dec.pairSel = 3'h0;
    endcase
    dif.dec.wdtOn    = dif.word[WDTEN_BIT];
    // A windowed request without the enable is not a valid setting, so it is
    // flagged and the standard watchdog stays selected.
    dif.dec.windowed = !dif.word[WINDOW_WATCHDOG_OFF_BIT] && dif.word[WDTEN_BIT];
    dif.dec.fault    = !dif.word[WINDOW_WATCHDOG_OFF_BIT] && !dif.word[WDTEN_BIT];
    dif.dec.prescale = dif.word[PSA_BIT] ? PRESCALE_HI : PRESCALE_LO;
  end

endmodule

// ===== verilog/config_word_decoder.sv
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module config_word_decoder #(
  parameter logic [2:0] MAJOR_REV = 3'h1,  // Arbitrary value.
  parameter logic [2:0] MINOR_REV = 3'h0   // Arbitrary value.
) (
  // Clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                rst_n,
  // Nonvolatile configuration storage
  input  wire logic [cfg_word_pkg::CFG_W-1:0]      nvConfig,
  output logic      [cfg_word_pkg::CFG_W-1:0]      nvProgramWord,
  output logic                                     nvProgramPulse,
  // Decoded static controls
  output logic                                     scanPortEnable,
  output logic                                     codeProtect,
  output logic                                     writeProtect,
  output logic                                     debugModeBoot,
  output logic      [2:0]                          emuPairSel,
  output logic                                     watchdogForceOn,
  output logic                                     watchdogWindowed,
  output logic      [7:0]                          watchdogPrescale,
  output logic                                     configFault,
  // AXI4-Lite write address and data
  input  wire logic [cfg_word_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [cfg_word_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]                          s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [cfg_word_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic      [cfg_word_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]                          s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready
);
  import cfg_word_pkg::*;

  load_state_t             state;
  decoded_t                decodedQ;
  logic [CFG_W-1:0]        storedWord;
  logic [CFG_W-1:0]        next_word;
  logic [CFG_W-1:0]        writeMask;
  logic [NUM_FIELDS-1:0]   programmed;
  logic [NUM_FIELDS-1:0]   fieldBlank;
  logic [NUM_FIELDS-1:0]   fieldWrite;
  logic                    run;
  logic                    awHeld;
  logic                    wHeld;
  logic                    doWrite;
  logic                    cfgHitW;
  logic                    knownW;
  logic                    next_awHeld;
  logic                    next_wHeld;
  logic                    next_bvalid;
  logic                    next_rvalid;
  logic [AXI_ADDR_W-1:0]   awAddrQ;
  logic [AXI_DATA_W-1:0]   wDataQ;
  logic [3:0]              wStrbQ;
  logic [AXI_DATA_W-1:0]   readData;
  logic [1:0]              readResp;

  cfg_decode_if dif ();

  cfg_field_decode u_decode (
    .dif (dif)
  );

  assign dif.word = storedWord;
  assign run      = (state == ST_RUN);

  // ----------------------------------------------------------------
  // Load sequence
  // ----------------------------------------------------------------
  // The word is loaded one cycle after reset release and decoded the cycle
  // after, so the decoder never sees a half-loaded word.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ST_LOAD;
    end else begin
      case (state)
        ST_LOAD:   state <= ST_DECODE;
        ST_DECODE: state <= ST_RUN;
        ST_RUN:    state <= ST_RUN;
        default:   state <= ST_LOAD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Decoded outputs
  // ----------------------------------------------------------------
  // Later programming only changes the stored image; the controls follow it
  // after the next reset, never mid-run.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      decodedQ <= DECODED_RST;
    end else if (state == ST_DECODE) begin
      decodedQ <= dif.dec;
    end
  end

  assign scanPortEnable   = decodedQ.scanEn;
  assign codeProtect      = decodedQ.codeProtect;
  assign writeProtect     = decodedQ.writeProtect;
  assign debugModeBoot    = decodedQ.debugBoot;
  assign emuPairSel       = decodedQ.pairSel;
  assign watchdogForceOn  = decodedQ.wdtOn;
  assign watchdogWindowed = decodedQ.windowed;
  assign watchdogPrescale = decodedQ.prescale;
  assign configFault      = decodedQ.fault;

  scan_decode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ST_DECODE) |=> scanPortEnable == $past(storedWord[SCAN_BIT]))
    else $error("scan port enable does not follow its bit");
  code_protect_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ST_DECODE) |=> codeProtect == !$past(storedWord[CP_BIT]))
    else $error("code protection has the wrong sense");
  write_protect_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ST_DECODE) |=> writeProtect == !$past(storedWord[WP_BIT]))
    else $error("write protection has the wrong sense");
  debug_boot_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ST_DECODE) |=> debugModeBoot == !$past(storedWord[DBG_BIT]))
    else $error("debug boot mode has the wrong sense");
  pair_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ST_DECODE && storedWord[ICS_LSB+:2] == ICS_PAIR2) |=> emuPairSel == 3'h2)
    else $error("emulator pair two not selected");
  wdt_force_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ST_DECODE && !storedWord[WDTEN_BIT]) |=> !watchdogForceOn)
    else $error("watchdog forced on while its bit is zero");
  window_valid_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    watchdogWindowed |-> watchdogForceOn && !configFault)
    else $error("windowed watchdog without enable");
  prescale_ratio_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ST_DECODE && !storedWord[PSA_BIT]) |=> watchdogPrescale == PRESCALE_LO)
    else $error("prescale is not 1:32");
  // Both senses of the scan, protect, debug, watchdog enable and prescale bits and all three pair codes are checked, so a swapped arm there is caught.
  pair_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ST_DECODE && storedWord[ICS_LSB+:2] == ICS_PAIR1) |=> emuPairSel == 3'h1)
    else $error("emulator pair one not selected");
  pair_three_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ST_DECODE && storedWord[ICS_LSB+:2] == ICS_PAIR3) |=> emuPairSel == 3'h4)
    else $error("emulator pair three not selected");
  wdt_enable_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ST_DECODE && storedWord[WDTEN_BIT]) |=> watchdogForceOn)
    else $error("watchdog not forced on while its bit is one");
  window_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ST_DECODE && storedWord[WDTEN_BIT] && !storedWord[WINDOW_WATCHDOG_OFF_BIT])
    |=> watchdogWindowed)
    else $error("windowed watchdog not selected");
  prescale_long_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ST_DECODE && storedWord[PSA_BIT]) |=> watchdogPrescale == PRESCALE_HI)
    else $error("prescale is not 1:128");
  hold_outputs_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    run ##1 run |-> $stable(decodedQ))
    else $error("decoded controls changed after load");

  // ----------------------------------------------------------------
  // Stored image and program-once control
  // ----------------------------------------------------------------
  for (genvar f = 0; f < NUM_FIELDS; f++) begin : g_field
    assign fieldBlank[f] = (nvConfig & FIELD_MASK[f]) == FIELD_MASK[f];
    // A field is only written when every byte lane it spans is strobed.
    assign fieldWrite[f] = doWrite && cfgHitW && !programmed[f]
                           && (FIELD_MASK[f][7:0] == 8'h00 || wStrbQ[0])
                           && (FIELD_MASK[f][15:8] == 8'h00 || wStrbQ[1]);
  end

  always_comb begin
    writeMask = '0;
    for (int i = 0; i < NUM_FIELDS; i++) begin
      if (fieldWrite[i]) begin
        writeMask = writeMask | FIELD_MASK[i];
      end
    end
    next_word = (storedWord & ~writeMask) | (wDataQ[CFG_W-1:0] & writeMask) | CFG_UNIMPL_MASK;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      storedWord <= CFG_BLANK;
    end else if (state == ST_LOAD) begin
      storedWord <= nvConfig | CFG_UNIMPL_MASK;
    end else if (|fieldWrite) begin
      storedWord <= next_word;
    end
  end

  // Fields already away from all ones came programmed out of storage.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      programmed <= '0;
    end else if (state == ST_LOAD) begin
      programmed <= ~fieldBlank;
    end else begin
      programmed <= programmed | fieldWrite;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nvProgramWord  <= CFG_BLANK;
      nvProgramPulse <= 1'h0;
    end else begin
      nvProgramPulse <= |fieldWrite;
      if (|fieldWrite) begin
        nvProgramWord <= next_word;
      end
    end
  end

  once_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (run && programmed[CP_FIELD]) |=> $stable(storedWord[CP_BIT]))
    else $error("programmed field changed");

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Address and data are held separately, so they may arrive in any order.
  assign cfgHitW = (awAddrQ == CFG_OFFSET);
  assign knownW  = cfgHitW || awAddrQ == REV_OFFSET || awAddrQ == STATUS_OFFSET;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_comb begin
    next_awHeld = awHeld || (s_axi_awvalid && s_axi_awready);
    next_wHeld  = wHeld || (s_axi_wvalid && s_axi_wready);
    if (doWrite) begin
      next_awHeld = 1'h0;
      next_wHeld  = 1'h0;
    end
    next_bvalid = (s_axi_bvalid && !s_axi_bready) || doWrite;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      awHeld        <= 1'h0;
      wHeld         <= 1'h0;
      s_axi_awready <= 1'h0;
      s_axi_wready  <= 1'h0;
      s_axi_bvalid  <= 1'h0;
      s_axi_bresp   <= RESP_OKAY;
      awAddrQ       <= '0;
      wDataQ        <= '0;
      wStrbQ        <= '0;
    end else begin
      awHeld        <= next_awHeld;
      wHeld         <= next_wHeld;
      s_axi_awready <= run && !next_awHeld && !next_bvalid;
      s_axi_wready  <= run && !next_wHeld && !next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddrQ <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bresp <= knownW ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always_comb begin
    readData = '0;
    readResp = RESP_OKAY;
    case (s_axi_araddr)
      CFG_OFFSET: begin
        readData[CFG_W-1:0] = storedWord | CFG_UNIMPL_MASK;
      end
      REV_OFFSET: begin
        readData[MAJOR_LSB+:3] = MAJOR_REV;
        readData[MINOR_LSB+:3] = MINOR_REV;
      end
      STATUS_OFFSET: begin
        readData[NUM_FIELDS-1:0]    = programmed;
        readData[STATUS_FAULT_BIT]  = decodedQ.fault;
        readData[STATUS_LOADED_BIT] = run;
      end
      default: begin
        readResp = RESP_SLVERR;
      end
    endcase
  end

  assign next_rvalid = (s_axi_rvalid && !s_axi_rready) || (s_axi_arvalid && s_axi_arready);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid  <= 1'h0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= run && !next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= readData;
        s_axi_rresp <= readResp;
      end
    end
  end

  upper_ones_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == CFG_OFFSET)
    |=> s_axi_rvalid && s_axi_rdata[23:16] == 8'hFF)
    else $error("config word upper byte not all ones");
  rev_major_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == REV_OFFSET)
    |=> s_axi_rdata[8:6] == MAJOR_REV)
    else $error("major revision misplaced");
  rev_minor_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == REV_OFFSET)
    |=> s_axi_rdata[2:0] == MINOR_REV)
    else $error("minor revision misplaced");
  rev_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == REV_OFFSET)
    |=> s_axi_rdata[23:9] == 15'h0000 && s_axi_rdata[5:3] == 3'h0)
    else $error("revision unimplemented bits not zero");

endmodule

// ===== test/tb_config_word_decoder.sv
`timescale 1ns/1ps
module tb_config_word_decoder import cfg_word_pkg::*;;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                  sys_clk = 1'b0;
  logic                  rst_n;
  logic [CFG_W-1:0]      nvConfig;
  logic [CFG_W-1:0]      nvProgramWord;
  logic                  nvProgramPulse;
  logic                  scanPortEnable, codeProtect, writeProtect, debugModeBoot;
  logic [2:0]            emuPairSel;
  logic                  watchdogForceOn, watchdogWindowed, configFault;
  logic [7:0]            watchdogPrescale;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [AXI_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready;
  int                    n_mismatch = 0;
  int                    checked = 0;
  int                    pulseCount = 0;
  logic [CFG_W-1:0]      lastProg = '0;

  always #4 sys_clk = ~sys_clk;

  config_word_decoder #(.MAJOR_REV(3'h5), .MINOR_REV(3'h3)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .nvConfig(nvConfig),
    .nvProgramWord(nvProgramWord), .nvProgramPulse(nvProgramPulse),
    .scanPortEnable(scanPortEnable), .codeProtect(codeProtect),
    .writeProtect(writeProtect), .debugModeBoot(debugModeBoot), .emuPairSel(emuPairSel),
    .watchdogForceOn(watchdogForceOn), .watchdogWindowed(watchdogWindowed),
    .watchdogPrescale(watchdogPrescale), .configFault(configFault),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // The persistence path is only valid while the pulse is high, so it is sampled then.
  always @(posedge sys_clk) begin
    if (nvProgramPulse === 1'b1) begin
      pulseCount <= pulseCount + 1;
      lastProg <= nvProgramWord;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  function automatic logic [31:0] exp_dec(input logic [CFG_W-1:0] w);
    logic [2:0] pair;
    case (w[9:8])
      2'b11:   pair = 3'b001;
      2'b10:   pair = 3'b010;
      2'b01:   pair = 3'b100;
      default: pair = 3'b000;
    endcase
    return {14'h0, w[14], ~w[13], ~w[12], ~w[11], pair, w[7], w[7] & ~w[6],
            (w[4] ? 8'h80 : 8'h20), ~w[7] & ~w[6]};
  endfunction

  function automatic logic [31:0] got_dec();
    return {14'h0, scanPortEnable, codeProtect, writeProtect, debugModeBoot, emuPairSel,
            watchdogForceOn, watchdogWindowed, watchdogPrescale, configFault};
  endfunction

  task automatic timeout();
    n_mismatch++;
    $display("CHECK FAILED %0t bus wait timed out", $time);
    final_report();
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      n++;
      if (n > 50) timeout();
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      n++;
      if (n > 50) timeout();
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, ed, "read data");
        check({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
      end
    end
  endtask

  // Reset is held eight cycles; decoded outputs settle on the second edge after release.
  task automatic do_reset(input logic [CFG_W-1:0] w);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    nvConfig <= w;
    repeat (8) @(posedge sys_clk);
    check(got_dec(), exp_dec(CFG_BLANK), "decode during reset");
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic run_case(input logic [CFG_W-1:0] w);
    do_reset(w);
    check(got_dec(), exp_dec(w), "decoded outputs");
    axi_read(CFG_OFFSET, {8'h00, 8'hFF, w[15:0]}, RESP_OKAY);
    nvConfig <= ~w;
    repeat (4) @(posedge sys_clk);
    check(got_dec(), exp_dec(w), "outputs held after capture");
  endtask

  task automatic program_once();
    int base;
    do_reset(CFG_BLANK);
    base = pulseCount;
    axi_read(STATUS_OFFSET, 32'h0002_0000, RESP_OKAY);
    axi_write(CFG_OFFSET, 32'h0, 4'h1, RESP_OKAY);
    axi_read(CFG_OFFSET, 32'h00FF_FF20, RESP_OKAY);
    axi_write(CFG_OFFSET, 32'h0000_0700, 4'h3, RESP_OKAY);
    axi_write(CFG_OFFSET, 32'hFFFF_7FFF, 4'hF, RESP_OKAY);
    axi_read(CFG_OFFSET, 32'h00FF_0720, RESP_OKAY);
    axi_read(STATUS_OFFSET, 32'h0002_07FF, RESP_OKAY);
    check(pulseCount - base, 2, "program pulse count");
    check({8'h0, lastProg}, 32'h00FF_0720, "persisted image");
    check(got_dec(), exp_dec(CFG_BLANK), "outputs unchanged by programming");
  endtask

  task automatic map_checks();
    axi_read(REV_OFFSET, 32'h0000_0143, RESP_OKAY);
    axi_write(REV_OFFSET, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    axi_read(REV_OFFSET, 32'h0000_0143, RESP_OKAY);
    axi_write(8'h0C, 32'h0, 4'hF, RESP_SLVERR);
    axi_read(8'h0C, 32'h0, RESP_SLVERR);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    nvConfig = CFG_BLANK;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    run_case(24'hFF_FFFF);
    run_case(24'h00_06AF);
    run_case(24'hFF_FD3F);
    run_case(24'hFF_FC7F);
    run_case(24'hFF_0420);
    axi_write(CFG_OFFSET, 32'hFFFF_7FFF, 4'hF, RESP_OKAY);
    axi_read(CFG_OFFSET, 32'h00FF_0420, RESP_OKAY);
    program_once();
    map_checks();
    final_report();
  end

endmodule
